// file: som_obj_model.sv
// Purpose: Breaker auxiliary contacts and cart position switches for the bench
// Assumes: Command pulses move the breaker one edge later
// Notes:   Fault modes let the bench show travel or stuck contacts
`timescale 1ns/10ps
`default_nettype none
module som_obj_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Commands from the block
  input  wire logic       i_open_cmd,
  input  wire logic       i_close_cmd,
  // Bench controls: cart 0 out,1 in,2 between,3 both; fault 0 none,1 both low,2 both high
  input  wire logic [1:0] i_cart_sel,
  input  wire logic [1:0] i_brk_fault,
  // Contacts
  output logic            o_open_sts,
  output logic            o_close_sts,
  output logic            o_cart_inserted_in,
  output logic            o_cart_removed_in
);
  logic closed_r;  // Breaker main contacts closed

  // Breaker follows the command pulses
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      closed_r <= 1'b0;
    end else if (i_open_cmd) begin
      closed_r <= 1'b0;
    end else if (i_close_cmd) begin
      closed_r <= 1'b1;
    end
  end

  // Contacts are high while the position holds, unless a fault is staged
  assign o_open_sts  = (i_brk_fault == 2'h0) ? !closed_r : (i_brk_fault == 2'h2);
  assign o_close_sts = (i_brk_fault == 2'h0) ? closed_r : (i_brk_fault == 2'h2);
  assign o_cart_inserted_in = (i_cart_sel == 2'h1) || (i_cart_sel == 2'h3);
  assign o_cart_removed_in  = (i_cart_sel == 2'h0) || (i_cart_sel == 2'h3);
endmodule
`default_nettype wire

// file: som_pkg.sv
// Purpose: Shared constants and types for the switchgear object monitor
// Assumes: Classic Wishbone slave with 32-bit data, byte addresses
// Notes:   Every offset, field position and reset value of the block lives here
package som_pkg;

  // Object type selection
  typedef enum logic [1:0] {
    OBJ_WD_BREAKER = 2'h0,  // Withdrawable breaker
    OBJ_BREAKER    = 2'h1,  // Fixed breaker
    OBJ_DISC_MC    = 2'h2,  // Main-circuit disconnector
    OBJ_DISC_GND   = 2'h3   // Earthing switch
  } som_obj_e;

  // Ready check selection
  typedef enum logic [1:0] {
    RDY_OFF  = 2'h0,  // Ready check not in use
    RDY_HIGH = 2'h1,  // Ready input must be high
    RDY_LOW  = 2'h2,  // Ready input must be low
    RDY_RSV  = 2'h3   // Illegal, treated as not in use
  } som_rdy_e;

  // Breaker position codes
  typedef enum logic [1:0] {
    BRK_BETWEEN = 2'h0,  // Neither status input active
    BRK_OPEN    = 2'h1,  // Open contact only
    BRK_CLOSED  = 2'h2,  // Close contact only
    BRK_FAULT   = 2'h3   // Both contacts active
  } som_brk_e;

  // Cart position codes
  typedef enum logic [2:0] {
    CART_POS_BETWEEN  = 3'h0,  // Neither cart input active
    CART_POS_REMOVED  = 3'h1,  // Cart pulled out
    CART_POS_INSERTED = 3'h2,  // Cart racked in
    CART_POS_FAULT    = 3'h3,  // Both cart inputs active
    CART_POS_UNUSED   = 3'h4   // Object type has no cart
  } som_cart_e;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;  // Configuration
  localparam logic [7:0] REG_CMD       = 8'h04;  // Open/close requests
  localparam logic [7:0] REG_STATUS    = 8'h08;  // Decoded state and flags
  localparam logic [7:0] REG_IRQ_STS   = 8'h0C;  // Sticky events, write one to clear
  localparam logic [7:0] REG_IRQ_MSK   = 8'h10;  // Event enables
  localparam logic [7:0] REG_STATS_CLR = 8'h14;  // Counter clear control
  localparam logic [7:0] REG_CNT_BASE  = 8'h18;  // First of four counters

  // Control field positions
  localparam int CTRL_TYPE_LSB = 0;  // Object type, two bits
  localparam int CTRL_SYNC_BIT = 2;  // Synchrocheck gating enable
  localparam int CTRL_RDY_LSB  = 3;  // Ready mode, two bits

  // Command bits
  localparam int CMD_OPEN_BIT  = 0;  // Open request
  localparam int CMD_CLOSE_BIT = 1;  // Close request

  // Status field positions
  localparam int STS_BRK_LSB   = 0;  // Breaker position, two bits
  localparam int STS_CART_LSB  = 2;  // Cart position, three bits
  localparam int STS_FLAG_LSB  = 5;  // Supplementary flags, four bits

  // Supplementary flag positions
  localparam int FLG_OPEN_OK  = 0;  // Opening allowed
  localparam int FLG_CLOSE_OK = 1;  // Closing allowed
  localparam int FLG_READY    = 2;  // Object ready
  localparam int FLG_SYNC     = 3;  // Synchronism satisfied
  localparam int FLG_W        = 4;

  // Event bits, shared by status and mask
  localparam int EV_OPEN_OK   = 0;  // Successful open request
  localparam int EV_CLOSE_OK  = 1;  // Successful close request
  localparam int EV_OPEN_ERR  = 2;  // Failed open request
  localparam int EV_CLOSE_ERR = 3;  // Failed close request
  localparam int EV_BRK_FAULT = 4;  // Breaker position turned bad
  localparam int EV_CART_FAULT = 5; // Cart position turned bad
  localparam int EV_W         = 6;

  // Counter indices
  localparam int CNT_OPEN_OK   = 0;
  localparam int CNT_CLOSE_OK  = 1;
  localparam int CNT_OPEN_ERR  = 2;
  localparam int CNT_CLOSE_ERR = 3;
  localparam int CNT_NUM       = 4;

  // Reset values
  localparam som_obj_e  RST_OBJ_TYPE = OBJ_BREAKER;
  localparam som_rdy_e  RST_RDY_MODE = RDY_OFF;
  localparam logic      RST_SYNC_EN  = 1'b0;

endpackage

// file: som_pos_dec.sv
// Purpose: Decode a pair of position contacts into a two-bit position code
// Assumes: Inputs already synchronous to the block clock
// Notes:   Code 0 neither, 1 first only, 2 second only, 3 both
`timescale 1ns/10ps
`default_nettype none
module som_pos_dec (
  // Contact inputs
  input  wire logic       i_first_on,
  input  wire logic       i_second_on,
  // Decoded code
  output logic [1:0]      o_code
);

  // Both contacts map straight onto the code bits, so both-on reads as fault
  always_comb begin
    o_code = {i_second_on, i_first_on};
  end

endmodule
`default_nettype wire

// file: som_top.sv
// Purpose: Status decoding, close permission and request statistics of one object
// Assumes: Classic Wishbone slave, 10 MHz clock, contact inputs synchronous
// Notes:   Requests arrive through the command register and are judged at once
//
// Overview of operation
// - Cart reads between when neither input set
// - Cart reads fault when both inputs set
// - Non-withdrawable types show cart not in use
// - Sync gating blocks close without sync ok
// - Ready check off, active high or low
// - Separate 32-bit successful open/close counters
// - Separate 32-bit failed open/close counters
// - Clear zeroes counters, control self-returns idle
// - Withdrawable: cart, position, control, full gating
// - Fixed breaker: position, control, gating, no cart
// - Disconnector: position and control, no gating
// - Earthing switch: indication only, no commands
// - Flags show open/close allowed, ready, sync
// - Breaker between when none, fault when both
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module som_top #(
  parameter int CNT_W = 32  // Width of each request counter
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  // Object contacts
  input  wire logic        i_open_sts,
  input  wire logic        i_close_sts,
  input  wire logic        i_cart_inserted_in,
  input  wire logic        i_cart_removed_in,
  // Gating inputs
  input  wire logic        i_ready,
  input  wire logic        i_sync_ok,
  input  wire logic        i_open_ilock,
  input  wire logic        i_close_ilock,
  // Commands and status
  output logic             o_open_cmd,
  output logic             o_close_cmd,
  output logic [1:0]       o_brk_pos,
  output logic [2:0]       o_cart_pos,
  output logic [3:0]       o_flags,
  output logic             o_irq
);

  // Whole state of the block
  typedef struct packed {
    logic                        ack;        // Bus acknowledge
    logic [31:0]                 dat;        // Bus read data
    som_pkg::som_obj_e           obj_type;   // Configured object type
    logic                        sync_en;    // Synchrocheck gating on
    som_pkg::som_rdy_e           rdy_mode;   // Ready check mode
    logic                        clr_pend;   // Counter clear in progress
    logic [som_pkg::EV_W-1:0]    irq_sts;    // Sticky events
    logic [som_pkg::EV_W-1:0]    irq_msk;    // Event enables
    logic [som_pkg::CNT_NUM-1:0][CNT_W-1:0] cnt;  // Request counters
    logic                        open_cmd;   // Open command pulse
    logic                        close_cmd;  // Close command pulse
    som_pkg::som_brk_e           brk_pos;    // Registered breaker position
    som_pkg::som_cart_e          cart_pos;   // Registered cart position
    logic [som_pkg::FLG_W-1:0]   flags;      // Registered flags
    logic                        irq;        // Interrupt level
  } som_state_s;

  som_state_s state_r;   // Current state
  som_state_s state_nxt; // Next state

  // Decoded contact codes
  logic [1:0] brk_code;   // Open is first, close is second
  logic [1:0] cart_code;  // Removed is first, inserted is second

  // Breaker contact decode
  som_pos_dec u_brk_dec (
    .i_first_on  (i_open_sts),
    .i_second_on (i_close_sts),
    .o_code      (brk_code)
  );

  // Cart contact decode
  som_pos_dec u_cart_dec (
    .i_first_on  (i_cart_removed_in),
    .i_second_on (i_cart_inserted_in),
    .o_code      (cart_code)
  );

  // Saturating increment, stops at the top value instead of wrapping
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    logic [CNT_W-1:0] top;
    top = '1;
    if (v == top) begin
      sat_inc = v;
    end else begin
      sat_inc = v + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Combinational helpers
  logic              bus_req;      // New bus cycle, not yet acknowledged
  logic              bus_wr;       // Write accepted this cycle
  logic              is_breaker;   // Either breaker type
  logic              has_control;  // Type may issue commands
  logic              ready_ok;     // Ready check satisfied
  logic              sync_ok;      // Synchronism check satisfied
  logic              open_ok;      // Opening permitted now
  logic              close_ok;     // Closing permitted now
  logic              req_open;     // Open requested by this write
  logic              req_close;    // Close requested by this write
  logic [3:0]        cnt_ev;       // Counter events this cycle
  logic [som_pkg::EV_W-1:0] ev;    // Interrupt events this cycle
  som_pkg::som_brk_e  brk_now;     // Breaker position from contacts
  som_pkg::som_cart_e cart_now;    // Cart position after type check
  logic [31:0]       rd_word;      // Read data for this access
  logic [7:0]        cnt_off;      // Byte offset of the access from the first counter

  // Next-state logic, one pass over the whole state per clock
  always_comb begin
    state_nxt = state_r;

    // Bus handshake: the acknowledge follows one cycle after the request is seen
    bus_req = i_wb_cyc && i_wb_stb && !state_r.ack;
    // A write commits at the edge where the master samples ack high, and not
    // at the edge that raises ack; a master that drops its cycle before the
    // answer therefore leaves every register untouched. Lanes other than the
    // lowest carry no fields, so only sel[0] qualifies a write.
    bus_wr  = i_wb_cyc && i_wb_stb && state_r.ack && i_wb_we && i_wb_sel[0];

    // Breaker position follows the contacts directly
    brk_now = som_pkg::som_brk_e'(brk_code);

    // Cart position only for the withdrawable type
    if (state_r.obj_type == som_pkg::OBJ_WD_BREAKER) begin
      cart_now = som_pkg::som_cart_e'({1'b0, cart_code});
    end else begin
      cart_now = som_pkg::CART_POS_UNUSED;
    end

    // Type features
    is_breaker  = (state_r.obj_type == som_pkg::OBJ_WD_BREAKER) ||
                  (state_r.obj_type == som_pkg::OBJ_BREAKER);
    has_control = (state_r.obj_type != som_pkg::OBJ_DISC_GND);

    // Ready check by selected polarity, illegal code acts as off
    // The spare code behaves as off so that a stray write cannot lock closing
    unique case (state_r.rdy_mode)
      som_pkg::RDY_HIGH: ready_ok = i_ready;
      som_pkg::RDY_LOW:  ready_ok = !i_ready;
      som_pkg::RDY_OFF:  ready_ok = 1'b1;
      som_pkg::RDY_RSV:  ready_ok = 1'b1;
    endcase

    // Synchronism ignored when gating is off
    sync_ok = !state_r.sync_en || i_sync_ok;

    // Opening: breakers respect their open interlock, disconnector does not
    open_ok = has_control && !(is_breaker && i_open_ilock);

    // Closing: gating applies to breaker types only; the cart position is
    // shown to software but is not itself a close condition
    if (is_breaker) begin
      close_ok = has_control && ready_ok && sync_ok && !i_close_ilock;
    end else begin
      close_ok = has_control;
    end

    // Requests are judged with the gating inputs present at the committing edge
    // Requests from the command register; open wins if both are set
    req_open  = bus_wr && (i_wb_adr == som_pkg::REG_CMD) &&
                i_wb_dat[som_pkg::CMD_OPEN_BIT];
    req_close = bus_wr && (i_wb_adr == som_pkg::REG_CMD) &&
                i_wb_dat[som_pkg::CMD_CLOSE_BIT] && !req_open;

    // Earthing switch ignores requests altogether: no pulse is issued and
    // neither outcome is counted, so the counters keep their values
    if (!has_control) begin
      req_open  = 1'b0;
      req_close = 1'b0;
    end

    // Outcomes, one per request
    cnt_ev = '0;
    cnt_ev[som_pkg::CNT_OPEN_OK]   = req_open  && open_ok;
    cnt_ev[som_pkg::CNT_CLOSE_OK]  = req_close && close_ok;
    cnt_ev[som_pkg::CNT_OPEN_ERR]  = req_open  && !open_ok;
    cnt_ev[som_pkg::CNT_CLOSE_ERR] = req_close && !close_ok;

    // One-cycle command pulses
    state_nxt.open_cmd  = cnt_ev[som_pkg::CNT_OPEN_OK];
    state_nxt.close_cmd = cnt_ev[som_pkg::CNT_CLOSE_OK];

    // Counters: clear finishes in one cycle, an outcome in that cycle still counts.
    // Saturation keeps a long-lived object from rolling over to a small count.
    for (int i = 0; i < som_pkg::CNT_NUM; i++) begin
      if (state_r.clr_pend) begin
        state_nxt.cnt[i] = {{(CNT_W-1){1'b0}}, cnt_ev[i]};
      end else if (cnt_ev[i]) begin
        state_nxt.cnt[i] = sat_inc(state_r.cnt[i]);
      end
    end

    // Clear control returns to idle once the clear has been applied
    state_nxt.clr_pend = 1'b0;

    // Events: outcomes plus entry into a bad position. Only the entry edge is
    // an event, so contacts stuck in the bad state raise the flag once and a
    // write-one-to-clear then stays cleared until the position recovers.
    ev = '0;
    ev[som_pkg::EV_OPEN_OK]    = cnt_ev[som_pkg::CNT_OPEN_OK];
    ev[som_pkg::EV_CLOSE_OK]   = cnt_ev[som_pkg::CNT_CLOSE_OK];
    ev[som_pkg::EV_OPEN_ERR]   = cnt_ev[som_pkg::CNT_OPEN_ERR];
    ev[som_pkg::EV_CLOSE_ERR]  = cnt_ev[som_pkg::CNT_CLOSE_ERR];
    ev[som_pkg::EV_BRK_FAULT]  = (brk_now == som_pkg::BRK_FAULT) &&
                                 (state_r.brk_pos != som_pkg::BRK_FAULT);
    ev[som_pkg::EV_CART_FAULT] = (cart_now == som_pkg::CART_POS_FAULT) &&
                                 (state_r.cart_pos != som_pkg::CART_POS_FAULT);

    // Register writes
    if (bus_wr) begin
      unique case (i_wb_adr)
        som_pkg::REG_CTRL: begin
          state_nxt.obj_type = som_pkg::som_obj_e'(
            i_wb_dat[som_pkg::CTRL_TYPE_LSB +: 2]);
          state_nxt.sync_en  = i_wb_dat[som_pkg::CTRL_SYNC_BIT];
          state_nxt.rdy_mode = som_pkg::som_rdy_e'(
            i_wb_dat[som_pkg::CTRL_RDY_LSB +: 2]);
        end
        som_pkg::REG_IRQ_STS: begin
          // Write one to clear
          state_nxt.irq_sts = state_r.irq_sts & ~i_wb_dat[som_pkg::EV_W-1:0];
        end
        som_pkg::REG_IRQ_MSK: begin
          state_nxt.irq_msk = i_wb_dat[som_pkg::EV_W-1:0];
        end
        som_pkg::REG_STATS_CLR: begin
          state_nxt.clr_pend = i_wb_dat[0];
        end
        default: begin
          // Command register, read-only and unmapped addresses store nothing
        end
      endcase
    end

    // New events set after any clear, so the set wins
    state_nxt.irq_sts = state_nxt.irq_sts | ev;

    // Registered decoded status and flags
    state_nxt.brk_pos  = brk_now;
    state_nxt.cart_pos = cart_now;
    state_nxt.flags = '0;
    state_nxt.flags[som_pkg::FLG_OPEN_OK]  = open_ok;
    state_nxt.flags[som_pkg::FLG_CLOSE_OK] = close_ok;
    state_nxt.flags[som_pkg::FLG_READY]    = ready_ok;
    state_nxt.flags[som_pkg::FLG_SYNC]     = sync_ok;

    // Interrupt level from the next status and mask, so that the level rises
    // at the same edge as the status bit and falls at the edge of the clear
    state_nxt.irq = |(state_nxt.irq_sts & state_nxt.irq_msk);

    // Read data selection
    rd_word = '0;
    cnt_off = i_wb_adr - som_pkg::REG_CNT_BASE;
    unique case (i_wb_adr)
      som_pkg::REG_CTRL: begin
        rd_word[som_pkg::CTRL_TYPE_LSB +: 2] = state_r.obj_type;
        rd_word[som_pkg::CTRL_SYNC_BIT]      = state_r.sync_en;
        rd_word[som_pkg::CTRL_RDY_LSB +: 2]  = state_r.rdy_mode;
      end
      som_pkg::REG_STATUS: begin
        rd_word[som_pkg::STS_BRK_LSB +: 2]  = state_r.brk_pos;
        rd_word[som_pkg::STS_CART_LSB +: 3] = state_r.cart_pos;
        rd_word[som_pkg::STS_FLAG_LSB +: som_pkg::FLG_W] = state_r.flags;
      end
      som_pkg::REG_IRQ_STS: begin
        rd_word[som_pkg::EV_W-1:0] = state_r.irq_sts;
      end
      som_pkg::REG_IRQ_MSK: begin
        rd_word[som_pkg::EV_W-1:0] = state_r.irq_msk;
      end
      som_pkg::REG_STATS_CLR: begin
        rd_word[0] = state_r.clr_pend;
      end
      default: begin
        // Counters sit in four words from the base, other addresses read zero.
        // The offset is judged at its full width: a word index cut to fewer
        // bits would let higher addresses alias onto the counters.
        if ((i_wb_adr >= som_pkg::REG_CNT_BASE) &&
            (cnt_off[7:2] < 6'(som_pkg::CNT_NUM)) &&
            (cnt_off[1:0] == 2'h0)) begin
          rd_word[CNT_W-1:0] = state_r.cnt[cnt_off[3:2]];
        end
      end
    endcase

    // Answer every access, mapped or not, one cycle after it starts
    state_nxt.ack = bus_req;
    if (bus_req && !i_wb_we) begin
      state_nxt.dat = rd_word;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // All fields start at zero, then the configuration and the cart code
      // take their own reset values; only constants appear here
      state_r          <= '0;
      state_r.obj_type <= som_pkg::RST_OBJ_TYPE;
      state_r.sync_en  <= som_pkg::RST_SYNC_EN;
      state_r.rdy_mode <= som_pkg::RST_RDY_MODE;
      state_r.cart_pos <= som_pkg::CART_POS_UNUSED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register
  // No output passes through logic after the flip-flops
  assign o_wb_dat    = state_r.dat;
  assign o_wb_ack    = state_r.ack;
  assign o_open_cmd  = state_r.open_cmd;
  assign o_close_cmd = state_r.close_cmd;
  assign o_brk_pos   = state_r.brk_pos;
  assign o_cart_pos  = state_r.cart_pos;
  assign o_flags     = state_r.flags;
  assign o_irq       = state_r.irq;

endmodule
`default_nettype wire

// file: som_top_sva.sv
// Purpose: Port-level checks of the switchgear object monitor
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Config is internal, so cart checks allow the not-in-use code
`timescale 1ns/10ps
`default_nettype none
module som_top_chk (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Bus and contacts
  input  wire logic       i_wb_cyc,
  input  wire logic       i_wb_stb,
  input  wire logic       o_wb_ack,
  input  wire logic       i_open_sts,
  input  wire logic       i_close_sts,
  input  wire logic       i_cart_inserted_in,
  input  wire logic       i_cart_removed_in,
  // Outputs
  input  wire logic       o_open_cmd,
  input  wire logic       o_close_cmd,
  input  wire logic [1:0] o_brk_pos,
  input  wire logic [2:0] o_cart_pos,
  input  wire logic [3:0] o_flags
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  ack_resp_a: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
    else $error("ack missing after request");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb) ##1 !o_wb_ack)
    else $error("ack without request or too long");
  brk_decode_a: assert property (1'b1 |=> o_brk_pos == {$past(i_close_sts), $past(i_open_sts)})
    else $error("breaker position wrong");
  cart_between_a: assert property ((!i_cart_inserted_in && !i_cart_removed_in) |=>
    o_cart_pos inside {3'h0, 3'h4}) else $error("cart between wrong");
  cart_fault_a: assert property ((i_cart_inserted_in && i_cart_removed_in) |=>
    o_cart_pos inside {3'h3, 3'h4}) else $error("cart fault wrong");
  cmd_ack_a: assert property ((o_open_cmd || o_close_cmd) |->
    $past(o_wb_ack) && !(o_open_cmd && o_close_cmd))
    else $error("command pulse not right after an answer");
  open_gate_a: assert property (o_open_cmd |-> o_flags[0] ##1 !o_open_cmd)
    else $error("open pulse while blocked");
  close_gate_a: assert property (o_close_cmd |-> o_flags[1] ##1 !o_close_cmd)
    else $error("close pulse while blocked");
endmodule
bind som_top som_top_chk u_chk (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_open_sts,
  .i_close_sts, .i_cart_inserted_in, .i_cart_removed_in, .o_open_cmd, .o_close_cmd, .o_brk_pos,
  .o_cart_pos, .o_flags);
`default_nettype wire

// file: tb.sv
// Purpose: Register-level tests of the switchgear object monitor
// Assumes: One-cycle Wishbone answer, narrow counters to reach saturation
// Notes:   Expected counts are tracked by the bench itself
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int CW = 4;  // Shortened counter width
  logic i_clk, i_rst_n, cyc, stb, we, rdy, syn, oil, cil, ack, oc, cc, irq;
  logic os, cs, ci, co;
  logic [7:0] adr;
  logic [31:0] wd, rdat, q;
  logic [1:0] cart, flt, bp;
  logic [2:0] cp;
  logic [3:0] flg;
  int error_cnt, n_tests, k, e_oo, e_co, e_cf;
  int n_close = 0;  // Close pulses counted on the relay output
  logic [4:0] t_ctl [8] = '{5'h04, 5'h04, 5'h09, 5'h11, 5'h19, 5'h01, 5'h0E, 5'h03};
  logic [7:0] t_in [8] = '{8'h0, 8'h1, 8'h0, 8'h0, 8'h0, 8'h4, 8'h0, 8'h0};  // b0 sync,b2 ilock
  int t_ok [8] = '{0, 1, 0, 1, 1, 0, 1, 2};  // 0 refused, 1 done, 2 ignored

  som_top #(.CNT_W(CW)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_open_sts(os), .i_close_sts(cs), .i_cart_inserted_in(ci), .i_cart_removed_in(co),
    .i_ready(rdy), .i_sync_ok(syn), .i_open_ilock(oil), .i_close_ilock(cil), .o_open_cmd(oc),
    .o_close_cmd(cc), .o_brk_pos(bp), .o_cart_pos(cp), .o_flags(flg), .o_irq(irq));
  som_obj_model u_obj (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_open_cmd(oc), .i_close_cmd(cc),
    .i_cart_sel(cart), .i_brk_fault(flt), .o_open_sts(os), .o_close_sts(cs),
    .o_cart_inserted_in(ci), .o_cart_removed_in(co));

  // Clock, 100 ns period
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Close pulses seen on the relay output
  always @(posedge i_clk) begin
    if (cc === 1'b1) n_close <= n_close + 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge i_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge i_clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      $display("BAD ack expected 1 seen 0");
    end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(5000 * 100);
    error_cnt++;
    $display("BAD watchdog expected done seen hang");
    end_sim();
  end

  initial begin
    {cyc, stb, we, rdy, syn, oil, cil, e_oo, e_co, e_cf} = '0;
    adr = 8'h00; wd = 32'h0; cart = 2'h1; flt = 2'h0; i_rst_n = 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chk("cart reset", {29'h0, cp}, 32'h4);
    rd_chk("ctrl reset", 8'h00, 32'h01);
    $display("Test reset done");
    for (k = 2; k >= 0; k--) begin
      flt <= k[1:0];
      rd_chk("brk pos", 8'h08, 32'(k == 2 ? 3 : (k == 0) ? 1 : 0) | 32'h1F0);
    end
    wb(1'b1, 8'h00, 32'h0);
    for (k = 0; k < 4; k++) begin
      cart <= k[1:0];
      wb(1'b0, 8'h08, 32'h0);
      chk("cart pos", {29'h0, q[4:2]}, k == 0 ? 1 : (k == 1) ? 2 : (k == 2) ? 0 : 3);
    end
    cart <= 2'h1;
    wb(1'b1, 8'h0C, 32'h3F);
    wb(1'b1, 8'h10, 32'h00);
    $display("Test decode done");
    for (k = 0; k < 8; k++) begin
      syn <= t_in[k][0]; cil <= t_in[k][2]; rdy <= 1'b0;
      wb(1'b1, 8'h00, {27'h0, t_ctl[k]});
      wb(1'b1, 8'h04, 32'h2);
      if (t_ok[k] == 1) e_co++;
      if (t_ok[k] == 0) e_cf++;
      wb(1'b1, 8'h04, 32'h1);
      if (t_ok[k] != 2) e_oo++;
    end
    rd_chk("cart unused", 8'h08, 32'h180 | 32'h10 | 32'h1);
    rd_chk("open ok cnt", 8'h18, e_oo);
    rd_chk("close ok cnt", 8'h1C, e_co);
    rd_chk("open fail cnt", 8'h20, 32'h0);
    rd_chk("close fail cnt", 8'h24, e_cf);
    chk("close pulses", n_close, e_co);
    $display("Test gating done");
    rd_chk("irq sts", 8'h0C, 32'h0B);
    chk("irq masked", irq, 1'b0);
    wb(1'b1, 8'h10, 32'h08);
    repeat (2) @(posedge i_clk);
    chk("irq on", irq, 1'b1);
    wb(1'b1, 8'h0C, 32'h08);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", irq, 1'b0);
    rd_chk("irq sts w1c", 8'h0C, 32'h03);
    $display("Test irq done");
    wb(1'b1, 8'h00, 32'h01);
    wb(1'b1, 8'h14, 32'h1);
    rd_chk("clear idle", 8'h14, 32'h0);
    for (k = 0; k < 4; k++) rd_chk("cleared", 8'h18 + 8'(4 * k), 32'h0);
    for (k = 0; k <= (1 << CW); k++) wb(1'b1, 8'h04, 32'h1);
    rd_chk("saturated", 8'h18, (1 << CW) - 1);
    rd_chk("unmapped", 8'h38, 32'h0);  // Would alias the saturated counter 0
    $display("Test stats done");
    end_sim();
  end
endmodule
`default_nettype wire
